// >>> rtl/flash_block_map.sv
// Purpose: Map a word index to its block bounds and write permission.
// Assumes: Fixed five-block layout from the package.
// Notes:   Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module flash_block_map
	import flash_seq_pkg::*;
(
	// Addressed word
	input  wire logic [WORD_IDX_W-1:0] wordIdx,
	// Protection bits, already qualified by the rewrite enable
	input  wire logic                  lowBlockEnable,
	input  wire logic                  userBlockEnable,
	// Block bounds and permission
	output logic      [WORD_IDX_W-1:0] blockBase,
	output logic      [WORD_IDX_W-1:0] blockTop,
	output logic                       writable
);

	// Small blocks always open, low blocks need both bits
	always_comb begin
		if (wordIdx <= BLK_A_TOP) begin
			blockBase = BLK_A_BASE;
			blockTop  = BLK_A_TOP;
			writable  = 1'b1;
		end else if (wordIdx <= BLK_B_TOP) begin
			blockBase = BLK_B_BASE;
			blockTop  = BLK_B_TOP;
			writable  = 1'b1;
		end else if (wordIdx <= BLK0_TOP) begin
			blockBase = BLK0_BASE;
			blockTop  = BLK0_TOP;
			writable  = lowBlockEnable & userBlockEnable;
		end else if (wordIdx <= BLK1_TOP) begin
			blockBase = BLK1_BASE;
			blockTop  = BLK1_TOP;
			writable  = lowBlockEnable & userBlockEnable;
		end else begin
			blockBase = BLK2_BASE;
			blockTop  = BLK2_TOP;
			writable  = userBlockEnable;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/flash_command_sequencer.sv
// Purpose: Command interpreter and auto program/erase sequencer for the user flash.
// Assumes: Classic Wishbone slave; array words at ARRAY base, one per bus word.
// Notes:   Array is flip-flops; auto operations are timed by a down counter.
//
// Overview of operation
// - 16-bit even accesses, command in low byte
// - Read-array code returns memory on reads
// - Read-status code makes reads return status
// - Clear-status code zeroes both error flags
// - Program code then data starts auto program
// - Ready reads 0 during auto program
// - Program error flag reports program result
// - Protected blocks refuse program and erase
// - RAM mode switches to status reads until read-array
// - Erase code then confirm at top erases block
// - Ready reads 0 during auto erase
// - Suspended flag 0 erasing, 1 when suspended
// - Erase error flag reports erase result
// - Main and aux enable bits need write 0 then 1
// - NMI or watchdog resets controls, aborts operation
// - Enable bits decide per-block write protection
// - Any error flag blocks program and erase
// - Bad or protected command sets both errors
// - Status bits 7, 5, 4: ready, erase, program
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
)(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Wishbone slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [WB_ADDR_W-1:0] adr_i,
	input  wire logic [WB_DATA_W-1:0] dat_i,
	output logic                      ack_o,
	output logic      [WB_DATA_W-1:0] dat_o,
	// Abort events
	input  wire logic                 nmiEvent,
	input  wire logic                 watchdogEvent,
	// Sequencer state
	output logic                      readyFlag
);

	localparam logic [CNT_W-1:0] PROG_LAST  = CNT_W'(PROG_CYCLES - 1);
	localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYCLES - 1);

	seq_state_type state_r, state_nxt;
	logic [CNT_W-1:0]      cnt_r, cnt_nxt;
	logic                  statusMode_r, statusMode_nxt;
	logic                  progErr_r, progErr_nxt, eraseErr_r, eraseErr_nxt;
	logic                  rewriteEn_r, rewriteEn_nxt, lowEn_r, lowEn_nxt;
	logic                  execSel_r, execSel_nxt, userEn_r, userEn_nxt;
	logic                  suspEn_r, suspEn_nxt, suspReq_r, suspReq_nxt;
	logic                  suspended_r, suspended_nxt;
	logic                  failProg_r, failProg_nxt, failErase_r, failErase_nxt;
	logic                  ready_nxt;
	logic [WORD_IDX_W-1:0] progIdx_r, progIdx_nxt;
	logic [WORD_W-1:0]     progData_r, progData_nxt;
	logic [WORD_IDX_W-1:0] eraseBase_r, eraseBase_nxt, eraseTop_r, eraseTop_nxt;
	logic                  lastValid_r, lastValid_nxt;
	logic [WB_ADDR_W-1:0]  lastOfs_r, lastOfs_nxt;
	logic [7:0]            lastData_r, lastData_nxt;
	logic                  ack_nxt;
	logic [WB_DATA_W-1:0]  dat_nxt;
	logic                  progWrite, eraseWrite;
	logic [WORD_W-1:0]     mem_r [WORD_COUNT];

	// Bus decode
	logic                  access, wrAcc, rdAcc, inArray, flashWr, abort, anyErr;
	logic [WORD_IDX_W-1:0] wordIdx, blkBase, blkTop;
	logic [7:0]            cmd, wrByte, statusByte, mainRd, auxRd, suspRd, failRd;
	logic                  blkWritable, sameReg;

	assign access  = cyc_i & stb_i & ~ack_o;
	assign wrAcc   = access & we_i;
	assign rdAcc   = access & ~we_i;
	assign inArray = adr_i[ARRAY_SEL_BIT];
	assign wordIdx = adr_i[WORD_IDX_W+1:2];
	assign cmd     = dat_i[7:0];             // Upper byte never decoded
	assign wrByte  = dat_i[7:0];
	assign flashWr = wrAcc & inArray & sel_i[0] & rewriteEn_r;
	assign abort   = nmiEvent | watchdogEvent;
	assign anyErr  = progErr_r | eraseErr_r;
	assign sameReg = lastValid_r & (lastOfs_r == adr_i);

	// Protection only counts while rewrite is enabled
	flash_block_map blockMap (
		.wordIdx         (wordIdx),
		.lowBlockEnable  (lowEn_r & rewriteEn_r),
		.userBlockEnable (userEn_r & rewriteEn_r),
		.blockBase       (blkBase),
		.blockTop        (blkTop),
		.writable        (blkWritable)
	);

	// Readable views of state
	always_comb begin
		statusByte = 8'h00;
		statusByte[SEQ_STATUS_BIT]   = readyFlag;
		statusByte[ERASE_STATUS_BIT] = eraseErr_r;
		statusByte[PROG_STATUS_BIT]  = progErr_r;
		mainRd = 8'h00;
		mainRd[READY_BIT]      = readyFlag;
		mainRd[REWRITE_EN_BIT] = rewriteEn_r;
		mainRd[LOW_EN_BIT]     = lowEn_r;
		mainRd[PROG_ERR_BIT]   = progErr_r;
		mainRd[ERASE_ERR_BIT]  = eraseErr_r;
		auxRd = 8'h00;
		auxRd[EXEC_SEL_BIT] = execSel_r;
		auxRd[USER_EN_BIT]  = userEn_r;
		suspRd = 8'h00;
		suspRd[SUSP_EN_BIT]   = suspEn_r;
		suspRd[SUSP_REQ_BIT]  = suspReq_r;
		suspRd[SUSPENDED_BIT] = suspended_r;
		failRd = 8'h00;
		failRd[FAIL_PROG_BIT]  = failProg_r;
		failRd[FAIL_ERASE_BIT] = failErase_r;
	end

	// Bus answer: one-cycle ack, unmapped reads return zero
	always_comb begin
		ack_nxt = access;
		dat_nxt = '0;
		if (rdAcc) begin
			if (inArray) begin
				if (statusMode_r)
					dat_nxt = {24'h000000, statusByte};
				else
					dat_nxt = {16'h0000, mem_r[wordIdx]};
			end else begin
				case (adr_i)
					MAIN_CTRL_OFS: dat_nxt = {24'h000000, mainRd};
					AUX_CTRL_OFS:  dat_nxt = {24'h000000, auxRd};
					SUSP_CTRL_OFS: dat_nxt = {24'h000000, suspRd};
					FAIL_CTRL_OFS: dat_nxt = {24'h000000, failRd};
					default:       dat_nxt = '0;
				endcase
			end
		end
	end

	// Control registers, command sequencer and auto operations
	always_comb begin
		state_nxt      = state_r;
		cnt_nxt        = cnt_r;
		statusMode_nxt = statusMode_r;
		progErr_nxt    = progErr_r;
		eraseErr_nxt   = eraseErr_r;
		rewriteEn_nxt  = rewriteEn_r;
		lowEn_nxt      = lowEn_r;
		execSel_nxt    = execSel_r;
		userEn_nxt     = userEn_r;
		suspEn_nxt     = suspEn_r;
		suspReq_nxt    = suspReq_r;
		failProg_nxt   = failProg_r;
		failErase_nxt  = failErase_r;
		progIdx_nxt    = progIdx_r;
		progData_nxt   = progData_r;
		eraseBase_nxt  = eraseBase_r;
		eraseTop_nxt   = eraseTop_r;
		lastValid_nxt  = lastValid_r;
		lastOfs_nxt    = lastOfs_r;
		lastData_nxt   = lastData_r;
		progWrite      = 1'b0;
		eraseWrite     = 1'b0;

		// Any write breaks a 0-then-1 pair unless it is the next half
		if (wrAcc) begin
			lastValid_nxt = ~inArray & sel_i[0];
			lastOfs_nxt   = adr_i;
			lastData_nxt  = wrByte;
		end

		// In the main and aux registers a 1 only lands right after a 0 to the same bit
		if (wrAcc && !inArray && sel_i[0]) begin
			case (adr_i)
				MAIN_CTRL_OFS: begin
					rewriteEn_nxt = wrByte[REWRITE_EN_BIT] &
						(rewriteEn_r | (sameReg & ~lastData_r[REWRITE_EN_BIT]));
					if (rewriteEn_r)
						lowEn_nxt = wrByte[LOW_EN_BIT] &
							(lowEn_r | (sameReg & ~lastData_r[LOW_EN_BIT]));
				end
				AUX_CTRL_OFS: begin
					if (rewriteEn_r) begin
						execSel_nxt = wrByte[EXEC_SEL_BIT] &
							(execSel_r | (sameReg & ~lastData_r[EXEC_SEL_BIT]));
						userEn_nxt = wrByte[USER_EN_BIT] &
							(userEn_r | (sameReg & ~lastData_r[USER_EN_BIT]));
					end
				end
				SUSP_CTRL_OFS: begin
					suspEn_nxt  = wrByte[SUSP_EN_BIT];
					suspReq_nxt = wrByte[SUSP_REQ_BIT];
				end
				FAIL_CTRL_OFS: begin
					failProg_nxt  = wrByte[FAIL_PROG_BIT];
					failErase_nxt = wrByte[FAIL_ERASE_BIT];
				end
				default: ;
			endcase
		end
		// Dropping rewrite enable also drops the flash-exec mode
		if (!rewriteEn_nxt)
			execSel_nxt = 1'b0;

		case (state_r)
			SEQ_READY: begin
				if (flashWr) begin
					case (cmd)
						CMD_READ_ARRAY:  statusMode_nxt = 1'b0;
						CMD_READ_STATUS: statusMode_nxt = 1'b1;
						CMD_CLEAR_STATUS: begin
							progErr_nxt  = 1'b0;
							eraseErr_nxt = 1'b0;
						end
						CMD_PROGRAM: begin
							if (!anyErr)
								state_nxt = SEQ_PROG_DATA;
						end
						CMD_ERASE: begin
							if (!anyErr)
								state_nxt = SEQ_ERASE_CONFIRM;
						end
						default: begin
							progErr_nxt  = 1'b1;
							eraseErr_nxt = 1'b1;
						end
					endcase
				end
			end
			SEQ_PROG_DATA: begin
				if (flashWr) begin
					if (!blkWritable) begin
						progErr_nxt  = 1'b1;
						eraseErr_nxt = 1'b1;
						state_nxt    = SEQ_READY;
					end else begin
						progIdx_nxt  = wordIdx;
						progData_nxt = dat_i[WORD_W-1:0];
						cnt_nxt      = PROG_LAST;
						state_nxt    = SEQ_PROGRAMMING;
						if (!execSel_r)
							statusMode_nxt = 1'b1;
					end
				end
			end
			SEQ_ERASE_CONFIRM: begin
				if (flashWr) begin
					state_nxt = SEQ_READY;
					if (cmd == CMD_READ_ARRAY) begin
						statusMode_nxt = 1'b0;
					end else if (cmd != CMD_ERASE_CONFIRM || !blkWritable ||
							wordIdx != blkTop) begin
						progErr_nxt  = 1'b1;
						eraseErr_nxt = 1'b1;
					end else begin
						eraseBase_nxt = blkBase;
						eraseTop_nxt  = blkTop;
						cnt_nxt       = ERASE_LAST;
						state_nxt     = SEQ_ERASING;
						if (!execSel_r)
							statusMode_nxt = 1'b1;
					end
				end
			end
			SEQ_PROGRAMMING: begin
				if (cnt_r == '0) begin
					state_nxt = SEQ_READY;
					// A written word cannot be reprogrammed
					progErr_nxt = failProg_r |
						(mem_r[progIdx_r] != ERASED_WORD);
					progWrite = ~progErr_nxt;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			SEQ_ERASING: begin
				if (suspEn_r && suspReq_r) begin
					state_nxt = SEQ_SUSPENDED;
				end else if (cnt_r == '0) begin
					state_nxt    = SEQ_READY;
					eraseErr_nxt = failErase_r;
					eraseWrite   = ~failErase_r;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			SEQ_SUSPENDED: begin
				// Array reads are allowed while the erase is parked
				if (flashWr && cmd == CMD_READ_ARRAY)
					statusMode_nxt = 1'b0;
				if (!suspReq_r || !suspEn_r)
					state_nxt = SEQ_ERASING;
			end
			default: state_nxt = SEQ_READY;
		endcase

		// Abort wins over everything, the array is left untouched
		if (abort) begin
			state_nxt      = SEQ_READY;
			statusMode_nxt = 1'b0;
			progErr_nxt    = MAIN_CTRL_RESET[PROG_ERR_BIT];
			eraseErr_nxt   = MAIN_CTRL_RESET[ERASE_ERR_BIT];
			rewriteEn_nxt  = MAIN_CTRL_RESET[REWRITE_EN_BIT];
			lowEn_nxt      = MAIN_CTRL_RESET[LOW_EN_BIT];
			execSel_nxt    = AUX_CTRL_RESET[EXEC_SEL_BIT];
			userEn_nxt     = AUX_CTRL_RESET[USER_EN_BIT];
			suspEn_nxt     = SUSP_CTRL_RESET[SUSP_EN_BIT];
			suspReq_nxt    = SUSP_CTRL_RESET[SUSP_REQ_BIT];
			progWrite      = 1'b0;
			eraseWrite     = 1'b0;
		end

		// Busy covers suspend too; suspended flag is 0 only while erasing
		ready_nxt = ~(state_nxt inside {SEQ_PROGRAMMING, SEQ_ERASING, SEQ_SUSPENDED});
		suspended_nxt = (state_nxt != SEQ_ERASING);
	end

	// Register the sequencer state; reset gives array mode and ready
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r      <= SEQ_READY;
			cnt_r        <= '0;
			statusMode_r <= 1'b0;
			readyFlag    <= MAIN_CTRL_RESET[READY_BIT];
			progErr_r    <= MAIN_CTRL_RESET[PROG_ERR_BIT];
			eraseErr_r   <= MAIN_CTRL_RESET[ERASE_ERR_BIT];
			rewriteEn_r  <= MAIN_CTRL_RESET[REWRITE_EN_BIT];
			lowEn_r      <= MAIN_CTRL_RESET[LOW_EN_BIT];
			execSel_r    <= AUX_CTRL_RESET[EXEC_SEL_BIT];
			userEn_r     <= AUX_CTRL_RESET[USER_EN_BIT];
			suspEn_r     <= SUSP_CTRL_RESET[SUSP_EN_BIT];
			suspReq_r    <= SUSP_CTRL_RESET[SUSP_REQ_BIT];
			suspended_r  <= SUSP_CTRL_RESET[SUSPENDED_BIT];
			failProg_r   <= FAIL_CTRL_RESET[FAIL_PROG_BIT];
			failErase_r  <= FAIL_CTRL_RESET[FAIL_ERASE_BIT];
			progIdx_r    <= '0;
			progData_r   <= '0;
			eraseBase_r  <= '0;
			eraseTop_r   <= '0;
			lastValid_r  <= 1'b0;
			lastOfs_r    <= '0;
			lastData_r   <= '0;
			ack_o        <= 1'b0;
			dat_o        <= '0;
		end else begin
			state_r      <= state_nxt;
			cnt_r        <= cnt_nxt;
			statusMode_r <= statusMode_nxt;
			readyFlag    <= ready_nxt;
			progErr_r    <= progErr_nxt;
			eraseErr_r   <= eraseErr_nxt;
			rewriteEn_r  <= rewriteEn_nxt;
			lowEn_r      <= lowEn_nxt;
			execSel_r    <= execSel_nxt;
			userEn_r     <= userEn_nxt;
			suspEn_r     <= suspEn_nxt;
			suspReq_r    <= suspReq_nxt;
			suspended_r  <= suspended_nxt;
			failProg_r   <= failProg_nxt;
			failErase_r  <= failErase_nxt;
			progIdx_r    <= progIdx_nxt;
			progData_r   <= progData_nxt;
			eraseBase_r  <= eraseBase_nxt;
			eraseTop_r   <= eraseTop_nxt;
			lastValid_r  <= lastValid_nxt;
			lastOfs_r    <= lastOfs_nxt;
			lastData_r   <= lastData_nxt;
			ack_o        <= ack_nxt;
			dat_o        <= dat_nxt;
		end
	end

	// Array words: erased at reset, written only by finished operations
	for (genvar i = 0; i < WORD_COUNT; i++) begin : gWord
		logic [WORD_W-1:0] memNxt;
		always_comb begin
			memNxt = mem_r[i];
			if (eraseWrite && WORD_IDX_W'(i) >= eraseBase_r && WORD_IDX_W'(i) <= eraseTop_r)
				memNxt = ERASED_WORD;
			else if (progWrite && progIdx_r == WORD_IDX_W'(i))
				memNxt = progData_r;
		end
		always_ff @(posedge clock) begin
			if (rst)
				mem_r[i] <= ERASED_WORD;
			else
				mem_r[i] <= memNxt;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/flash_seq_pkg.sv
// Purpose: Shared constants and types for the flash command sequencer.
// Assumes: 32-bit classic Wishbone with byte addresses, one register per word.
// Notes:   Array words sit one per bus word above the array base.
package flash_seq_pkg;

	// Bus and array geometry
	localparam int WB_ADDR_W  = 9;
	localparam int WB_DATA_W  = 32;
	localparam int WORD_W     = 16;
	localparam int WORD_IDX_W = 6;
	localparam int WORD_COUNT = 64;

	// Register offsets (byte addresses)
	localparam logic [WB_ADDR_W-1:0] MAIN_CTRL_OFS = 9'h000;
	localparam logic [WB_ADDR_W-1:0] AUX_CTRL_OFS  = 9'h004;
	localparam logic [WB_ADDR_W-1:0] SUSP_CTRL_OFS = 9'h008;
	localparam logic [WB_ADDR_W-1:0] FAIL_CTRL_OFS = 9'h00c;
	localparam int                   ARRAY_SEL_BIT = 8;

	// Main control fields
	localparam int READY_BIT      = 0;
	localparam int REWRITE_EN_BIT = 1;
	localparam int LOW_EN_BIT     = 2;
	localparam int PROG_ERR_BIT   = 6;
	localparam int ERASE_ERR_BIT  = 7;
	// Aux control fields
	localparam int EXEC_SEL_BIT   = 1;
	localparam int USER_EN_BIT    = 6;
	// Suspend control fields
	localparam int SUSP_EN_BIT    = 0;
	localparam int SUSP_REQ_BIT   = 1;
	localparam int SUSPENDED_BIT  = 6;
	// Verify failure injection fields
	localparam int FAIL_PROG_BIT  = 0;
	localparam int FAIL_ERASE_BIT = 1;
	// Status byte fields
	localparam int SEQ_STATUS_BIT   = 7;
	localparam int ERASE_STATUS_BIT = 5;
	localparam int PROG_STATUS_BIT  = 4;

	// Reset values of the readable registers
	localparam logic [7:0] MAIN_CTRL_RESET = 8'h01;
	localparam logic [7:0] AUX_CTRL_RESET  = 8'h00;
	localparam logic [7:0] SUSP_CTRL_RESET = 8'h40;
	localparam logic [7:0] FAIL_CTRL_RESET = 8'h00;

	// Command codes, low byte only
	localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
	localparam logic [7:0] CMD_PROGRAM       = 8'h40;
	localparam logic [7:0] CMD_ERASE         = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;

	localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;

	// Auto operation lengths in clock cycles
	localparam int PROG_CYCLES_DEF  = 64;
	localparam int ERASE_CYCLES_DEF = 512;
	localparam int CNT_W            = 16;

	// Block layout in word indices
	localparam logic [WORD_IDX_W-1:0] BLK_A_BASE = 6'h00;
	localparam logic [WORD_IDX_W-1:0] BLK_A_TOP  = 6'h07;
	localparam logic [WORD_IDX_W-1:0] BLK_B_BASE = 6'h08;
	localparam logic [WORD_IDX_W-1:0] BLK_B_TOP  = 6'h0f;
	localparam logic [WORD_IDX_W-1:0] BLK0_BASE  = 6'h10;
	localparam logic [WORD_IDX_W-1:0] BLK0_TOP   = 6'h1f;
	localparam logic [WORD_IDX_W-1:0] BLK1_BASE  = 6'h20;
	localparam logic [WORD_IDX_W-1:0] BLK1_TOP   = 6'h2f;
	localparam logic [WORD_IDX_W-1:0] BLK2_BASE  = 6'h30;
	localparam logic [WORD_IDX_W-1:0] BLK2_TOP   = 6'h3f;

	typedef enum logic [2:0] {
		SEQ_READY,
		SEQ_PROG_DATA,
		SEQ_ERASE_CONFIRM,
		SEQ_PROGRAMMING,
		SEQ_ERASING,
		SEQ_SUSPENDED
	} seq_state_type;

endpackage

// >>> verif/cpu_bus_model.sv
// Purpose: Rewrite-program CPU issuing classic single bus cycles.
// Assumes: Slave acks every request.
// Notes:   Released write data shows the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
	import flash_seq_pkg::*;
(
	// Clock
	input  wire logic                 clock,
	// Master side
	output logic                      cyc,
	output logic                      stb,
	output logic                      we,
	output logic      [3:0]           sel,
	output logic      [WB_ADDR_W-1:0] adr,
	output logic      [WB_DATA_W-1:0] dat,
	input  wire logic                 ack,
	input  wire logic [WB_DATA_W-1:0] rdat
);
	// Idle at start; sole master: no DMA, wait, stop or clock halt
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		adr = '0;
		dat = '0;
	end
	// One cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [WB_ADDR_W-1:0] a,
		input logic [WB_DATA_W-1:0] d, output logic [WB_DATA_W-1:0] r);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h3; // 16-bit lanes only
		adr <= {a[8:2], 2'b00}; // Always an even word
		dat <= d;
		do @(posedge clock); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> verif/flash_command_sequencer_assertions.sv
// Purpose: Port-level temporal checks of the flash command sequencer.
// Assumes: PROG_CYCLES of at least 2; benches keep suspends short.
// Notes:   Bound to every sequencer instance.
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer_assertions
	import flash_seq_pkg::*;
#(
	parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
)(
	// Clock and reset
	input wire logic                 clock,
	input wire logic                 rst,
	// Bus
	input wire logic                 cyc_i,
	input wire logic                 stb_i,
	input wire logic                 we_i,
	input wire logic [3:0]           sel_i,
	input wire logic [WB_ADDR_W-1:0] adr_i,
	input wire logic [WB_DATA_W-1:0] dat_i,
	input wire logic                 ack_o,
	input wire logic [WB_DATA_W-1:0] dat_o,
	// Events and state
	input wire logic                 nmiEvent,
	input wire logic                 watchdogEvent,
	input wire logic                 readyFlag
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Busy stretch length; a counter because a long repetition would stall the tools
	logic [CNT_W-1:0] lowCnt_r;
	logic [CNT_W-1:0] lowCnt_nxt;
	always_comb lowCnt_nxt = readyFlag ? '0 : lowCnt_r + 16'h1;
	always_ff @(posedge clock) lowCnt_r <= rst ? '0 : lowCnt_nxt;

	property p_ackPulse; ack_o |=> !ack_o; endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack held too long");
	property p_ackAns; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ackAns: assert property (p_ackAns) else $error("request not acked");
	property p_noAck; !(cyc_i && stb_i) |=> !ack_o; endproperty
	a_noAck: assert property (p_noAck) else $error("ack without request");
	property p_datIdle; !ack_o |-> dat_o == '0; endproperty
	a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
	property p_abort; nmiEvent || watchdogEvent |=> readyFlag; endproperty
	a_abort: assert property (p_abort) else $error("abort left sequencer busy");
	property p_resetReady; $fell(rst) |-> readyFlag && !ack_o; endproperty
	a_resetReady: assert property (p_resetReady) else $error("not ready after reset");
	property p_busyStart; $fell(readyFlag) |-> ack_o && $past(we_i); endproperty
	a_busyStart: assert property (p_busyStart) else $error("busy without write");
	property p_busyMin; $rose(readyFlag) |-> lowCnt_r >= CNT_W'(PROG_CYCLES - 1); endproperty
	a_busyMin: assert property (p_busyMin) else $error("operation too short");
	property p_busyMax; $fell(readyFlag) |-> ##[1:300] readyFlag; endproperty
	a_busyMax: assert property (p_busyMax) else $error("operation never ended");
	property p_mainMirror;
		cyc_i && stb_i && !ack_o && !we_i && adr_i == MAIN_CTRL_OFS
			|=> dat_o[READY_BIT] == $past(readyFlag) && dat_o[31:8] == 24'h0;
	endproperty
	a_mainMirror: assert property (p_mainMirror) else $error("ready bit mismatch");
	// Main scenarios reached
	c_busy: cover property ($fell(readyFlag));
	c_abort: cover property (nmiEvent && !readyFlag);
	c_longBusy: cover property (lowCnt_r == CNT_W'(ERASE_CYCLES));
endmodule
bind flash_command_sequencer flash_command_sequencer_assertions #(
	.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)
) chk (.clock(clock), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
	.nmiEvent(nmiEvent), .watchdogEvent(watchdogEvent), .readyFlag(readyFlag));
`default_nettype wire

// >>> verif/flash_command_sequencer_bench.sv
// Purpose: Self-checking bench of the flash command sequencer.
// Assumes: RAM-exec rewrite mode except the second abort pass, so operations switch to status reads.
// Notes:   Short auto-operation counts keep the run brief.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module flash_command_sequencer_bench
	import flash_seq_pkg::*;
;
	logic                 clock = 1'b0;
	logic                 rst = 1'b1;
	logic                 nmiEvent = 1'b0;
	logic                 watchdogEvent = 1'b0;
	logic                 cyc, stb, we, ack, readyFlag;
	logic [3:0]           sel;
	logic [WB_ADDR_W-1:0] adr;
	logic [WB_DATA_W-1:0] wdat, rdat;
	int                   bad_count = 0;
	int                   num_checks = 0;
	logic [5:0]           idx [4];
	logic [15:0]          word [4];
	logic [8:0]           ofs [5] = '{9'h000, 9'h004, 9'h008, 9'h00c, 9'h010};
	logic [7:0]           rv [5] = '{MAIN_CTRL_RESET, AUX_CTRL_RESET, SUSP_CTRL_RESET,
		FAIL_CTRL_RESET, 8'h00};
	// Clock
	always #5 clock = ~clock;
	// Design and its bus master
	flash_command_sequencer #(.PROG_CYCLES(6), .ERASE_CYCLES(16)) DUT (.clock(clock),
		.rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr),
		.dat_i(wdat), .ack_o(ack), .dat_o(rdat), .nmiEvent(nmiEvent),
		.watchdogEvent(watchdogEvent), .readyFlag(readyFlag));
	cpu_bus_model cpu (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .sel(sel),
		.adr(adr), .dat(wdat), .ack(ack), .rdat(rdat));
	// Bus helpers
	task automatic rg(input logic w, input logic [8:0] a, input logic [7:0] d,
		output logic [7:0] r);
		logic [WB_DATA_W-1:0] x;
		cpu.xfer(w, a, {24'h0, d}, x);
		r = x[7:0];
	endtask
	task automatic aw(input logic [5:0] i, input logic [15:0] d);
		logic [WB_DATA_W-1:0] x;
		cpu.xfer(1'b1, {1'b1, i, 2'b00}, {16'h0, d}, x);
	endtask
	task automatic ar(input logic [5:0] i, output logic [15:0] r);
		logic [WB_DATA_W-1:0] x;
		cpu.xfer(1'b0, {1'b1, i, 2'b00}, '0, x);
		r = x[15:0];
	endtask
	// Upper byte random: it must be ignored
	task automatic cm(input logic [5:0] i, input logic [7:0] c);
		aw(i, {8'($urandom), c});
	endtask
	task automatic st(input logic [7:0] e, output logic [7:0] r);
		logic [15:0] x;
		ar(6'($urandom), x);
		r = x[7:0];
		`CHK("status", e, r);
	endtask
	task automatic prog(input logic [5:0] i, input logic [15:0] d);
		cm(i, CMD_PROGRAM);
		aw(i, d);
	endtask
	task automatic erase(input logic [5:0] top);
		cm(top, CMD_ERASE);
		cm(top, CMD_ERASE_CONFIRM);
	endtask
	// Zero-then-one writes of the enables; u is the aux value
	task automatic enable(input logic [7:0] u);
		logic [7:0] r;
		logic [15:0] t [6] = '{16'h0000, 16'h0002, 16'h0002, 16'h0006, 16'h0400, 16'h0400};
		t[5][7:0] = u;
		foreach (t[k]) rg(1'b1, {1'b0, t[k][15:8]}, t[k][7:0], r);
	endtask
	// Bounded wait for ready
	task automatic wrdy();
		for (int n = 0; n < 400 && readyFlag !== 1'b1; n++) @(negedge clock);
		`CHK("ready", 1'b1, readyFlag);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		final_report();
	end
	// Main sequence
	initial begin
		logic [7:0] r;
		logic [15:0] w;
		void'($urandom(73046));
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		foreach (ofs[k]) begin
			rg(1'b0, ofs[k], 8'h00, r);
			`CHK("reset reg", rv[k], r);
		end
		ar(6'($urandom), w);
		`CHK("erased word", ERASED_WORD, w);
		// Set with its zero write to the same register broken by a write to another register
		rg(1'b1, MAIN_CTRL_OFS, 8'h00, r);
		rg(1'b1, AUX_CTRL_OFS, 8'h00, r);
		rg(1'b1, MAIN_CTRL_OFS, 8'h02, r);
		rg(1'b0, MAIN_CTRL_OFS, 8'h00, r);
		`CHK("refused set", 8'h01, r);
		enable(8'h40);
		rg(1'b0, MAIN_CTRL_OFS, 8'h00, r);
		`CHK("enabled", 8'h07, r);
		$display("test reset and enables done");
		// One fresh word per block group, never reprogrammed
		for (int k = 0; k < 4; k++) begin
			idx[k] = {k[1:0], 4'($urandom)};
			word[k] = 16'($urandom) & 16'hfffe;
			prog(idx[k], word[k]);
			st(8'h00, r);
			wrdy();
			st(8'h80, r);
			cm(idx[k], CMD_READ_ARRAY);
			ar(idx[k], w);
			`CHK("programmed", word[k], w);
		end
		$display("test program done");
		rg(1'b1, FAIL_CTRL_OFS, 8'h01, r);
		prog(idx[0] ^ 6'h1, 16'h1234);
		wrdy();
		st(8'h90, r);
		prog(idx[0] ^ 6'h1, 16'h1234);
		@(negedge clock);
		`CHK("rejected", 1'b1, readyFlag);
		cm(idx[0] ^ 6'h1, CMD_CLEAR_STATUS);
		st(8'h80, r);
		rg(1'b1, FAIL_CTRL_OFS, 8'h00, r);
		cm(6'($urandom), 8'h33);
		st(8'hb0, r);
		cm(6'h00, CMD_CLEAR_STATUS);
		rg(1'b1, AUX_CTRL_OFS, 8'h00, r);
		prog(idx[3] ^ 6'h1, 16'h0);
		st(8'hb0, r);
		cm(idx[3] ^ 6'h1, CMD_CLEAR_STATUS);
		$display("test errors done");
		enable(8'h40);
		erase(6'h2f);
		rg(1'b0, SUSP_CTRL_OFS, 8'h00, r);
		`CHK("erasing", 1'b0, r[SUSPENDED_BIT]);
		rg(1'b1, SUSP_CTRL_OFS, 8'h03, r);
		rg(1'b0, SUSP_CTRL_OFS, 8'h00, r);
		`CHK("suspended", 1'b1, r[SUSPENDED_BIT]);
		`CHK("busy suspended", 1'b0, readyFlag);
		rg(1'b1, SUSP_CTRL_OFS, 8'h01, r);
		wrdy();
		st(8'h80, r);
		cm(6'h2f, CMD_READ_ARRAY);
		ar(idx[2], w);
		`CHK("erased", ERASED_WORD, w);
		// Failed erase, then clear and retry
		for (int k = 0; k < 3; k++) begin
			rg(1'b1, FAIL_CTRL_OFS, (k == 0) ? 8'h02 : 8'h00, r);
			cm(6'h1f, CMD_CLEAR_STATUS);
			erase(6'h1f);
			wrdy();
			st((k == 0) ? 8'ha0 : 8'h80, r);
			if (r[ERASE_STATUS_BIT] === 1'b0) break;
		end
		$display("test erase done");
		// Abort a suspended erase by each event
		for (int k = 0; k < 2; k++) begin
			enable(k ? 8'h42 : 8'h40);
			erase(6'h3f);
			ar(idx[3], w);
			`CHK("exec read", k ? word[3] : 16'h0000, w);
			rg(1'b1, SUSP_CTRL_OFS, 8'h03, r);
			@(posedge clock);
			nmiEvent <= (k == 0);
			watchdogEvent <= (k == 1);
			@(posedge clock);
			nmiEvent <= 1'b0;
			watchdogEvent <= 1'b0;
			@(negedge clock);
			`CHK("abort ready", 1'b1, readyFlag);
			rg(1'b0, MAIN_CTRL_OFS, 8'h00, r);
			`CHK("abort main", MAIN_CTRL_RESET, r);
			ar(idx[3], w);
			`CHK("abort word", word[3], w);
		end
		$display("test abort done");
		final_report();
	end
endmodule
`default_nettype wire
